/* File: stroke_char_rom_decoder.v */
// Character stroke store, byte multiplexer and stroke decoder
`include "stroke_rom_defs.vh"
module stroke_char_rom_decoder #(
  parameter CODE_W = 6,
  parameter WORD_W = 32
) (
  input  wire             clock,
  input  wire             rstn,
  input  wire             ce,
  input  wire             code_load_pulse,
  input  wire [6:0]       char_code,
  input  wire             rom_we,
  input  wire [CODE_W:0]  rom_waddr,
  input  wire [WORD_W-1:0] rom_wdata,
  output wire             stroke_valid,
  input  wire             stroke_ready,
  output wire             stroke_escape_out,
  output wire             stroke_intensity_out,
  output wire [2:0]       stroke_direction_out,
  output wire [2:0]       stroke_length_out,
  output wire             beam_on,
  output reg              function_code,
  output reg  [6:0]       function_value,
  output reg              busy
);
  localparam ST_IDLE = 2'h0;
  localparam ST_RUN  = 2'h1;
  localparam ST_DONE = 2'h2;

  // Stroke store: one word per (code, word select)
  reg [WORD_W-1:0] rom [0:(1<<(CODE_W+1))-1];
  reg [CODE_W-1:0] code_q;
  reg              code_high_bit_flag;
  reg              word_sel_q;
  reg [1:0]        byte_cnt_q;
  reg [1:0]        state_q;
  reg              ld_s1_q;
  reg              ld_s2_q;
  reg              ld_s3_q;
  reg [6:0]        cc_s1_q;
  reg [6:0]        cc_s2_q;
  wire             load_evt;
  wire [2:0]       board_sel;
  wire [2:0]       char_sel;
  wire [WORD_W-1:0] word;
  reg  [7:0]       sbyte;
  wire             push;
  wire             fifo_ready;
  wire [7:0]       fifo_in;
  wire [7:0]       fifo_out;
  wire             is_func;
  wire             inhibit;

  // Pin synchronisers for the load pulse and code lines
  always @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      ld_s1_q <= 1'b0;
      ld_s2_q <= 1'b0;
      ld_s3_q <= 1'b0;
      cc_s1_q <= 7'h00;
      cc_s2_q <= 7'h00;
    end
    else if (ce)
    begin
      ld_s1_q <= code_load_pulse;
      ld_s2_q <= ld_s1_q;
      ld_s3_q <= ld_s2_q;
      cc_s1_q <= char_code;
      cc_s2_q <= cc_s1_q;
    end
  end
  assign load_evt = ld_s2_q && !ld_s3_q;

  // Store writes from the loader port
  always @(posedge clock)
  begin
    if (ce && rom_we)
      rom[rom_waddr] <= rom_wdata;
  end

  assign board_sel = code_q[CODE_W-1:CODE_W-3];
  assign char_sel  = code_q[2:0];
  // board select plus character select forms the store row
  // word select picks first or second word
  assign word = rom[{word_sel_q, board_sel, char_sel}];

  // byte counter picks one of four bytes
  always @*
  begin
    case (byte_cnt_q)
      2'h0:    sbyte = word[31:24];
      2'h1:    sbyte = word[23:16];
      2'h2:    sbyte = word[15:8];
      default: sbyte = word[7:0];
    endcase
  end

  // equal high flag and top bit mean no stored character
  assign inhibit = (code_high_bit_flag == code_q[CODE_W-1]);
  assign is_func = inhibit && (({code_high_bit_flag, code_q} == `CODE_TAB) ||
                   ({code_high_bit_flag, code_q} == `CODE_LF) ||
                   ({code_high_bit_flag, code_q} == `CODE_CR) ||
                   ({code_high_bit_flag, code_q} == `CODE_ALT));

  // escape, intensity on, direction, length order
  assign fifo_in = {sbyte[`SB_ESC],
                    (sbyte[`SB_INT_HI:`SB_INT_LO] == `INT_ON),
                    sbyte[`SB_DIR_HI:`SB_DIR_LO],
                    sbyte[`SB_LEN_HI:`SB_LEN_LO]};
  // Only stored characters push; a fresh load takes precedence
  assign push = (state_q == ST_RUN) && fifo_ready && !inhibit && !load_evt;

  // Sequencer: load, step bytes, stop at escape
  always @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      code_q             <= {CODE_W{1'b0}};
      code_high_bit_flag <= 1'b0;
      word_sel_q         <= `WORD_SEL_RST;
      byte_cnt_q         <= `BYTE_CNT_RST;
      state_q            <= ST_IDLE;
      function_code      <= 1'b0;
      function_value     <= 7'h00;
      busy               <= 1'b0;
    end
    else if (ce)
    begin
      function_code <= 1'b0;
      if (load_evt)
      begin
        // load six low bits and high flag
        code_q             <= cc_s2_q[5:0];
        code_high_bit_flag <= cc_s2_q[6];
        byte_cnt_q         <= `BYTE_CNT_RST;
        word_sel_q         <= `WORD_SEL_RST;
        state_q            <= ST_RUN;
        busy               <= 1'b1;
      end
      else
      begin
        case (state_q)
          ST_IDLE:
            busy <= 1'b0;
          ST_RUN:
          begin
            if (is_func)
            begin
              function_code  <= 1'b1;
              function_value <= {code_high_bit_flag, code_q};
              state_q        <= ST_DONE;
              busy           <= 1'b0;
            end
            else if (inhibit)
            begin
              state_q <= ST_DONE;
              busy    <= 1'b0;
            end
            else if (push)
            begin
              // stop and wait for next load
              // at most eight moves, then stop
              if (sbyte[`SB_ESC] || (word_sel_q && byte_cnt_q == 2'h3))
              begin
                state_q <= ST_DONE;
                busy    <= 1'b0;
              end
              else
              begin
                byte_cnt_q <= byte_cnt_q + 2'h1;
                // flip word select after first word
                if (byte_cnt_q == 2'h3)
                  word_sel_q <= ~word_sel_q;
              end
            end
          end
          ST_DONE:
            busy <= 1'b0;
          default:
            state_q <= ST_IDLE;
        endcase
      end
    end
  end

  // Stroke FIFO toward the generator
  stroke_fifo #(
    .WIDTH (`STROKE_W),
    .DEPTH (`FIFO_DEPTH),
    .AW    (`FIFO_AW)
  ) u_fifo (
    .clock     (clock),
    .rstn      (rstn),
    .ce        (ce),
    .in_data   (fifo_in),
    .in_valid  (push),
    .in_ready  (fifo_ready),
    .out_data  (fifo_out),
    .out_valid (stroke_valid),
    .out_ready (stroke_ready)
  );

  // length bits feed length register bits 14..16
  assign stroke_escape_out    = fifo_out[7];
  assign stroke_intensity_out = fifo_out[6];
  assign stroke_direction_out = fifo_out[5:3];
  assign stroke_length_out    = fifo_out[2:0];
  // intensity field value 1 turns beam on
  assign beam_on = stroke_valid && fifo_out[6];
endmodule

// Stroke output FIFO with valid and ready on both sides
module stroke_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  input  wire             clock,
  input  wire             rstn,
  input  wire             ce,
  input  wire [WIDTH-1:0] in_data,
  input  wire             in_valid,
  output wire             in_ready,
  output reg  [WIDTH-1:0] out_data,
  output wire             out_valid,
  input  wire             out_ready
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wr_q;
  reg [AW-1:0]    rd_q;
  reg [AW:0]      cnt_q;
  wire            push;
  wire            pop;

  // Depth must be two to the AW: the top count bit alone marks full
  assign in_ready  = !cnt_q[AW];
  assign out_valid = (cnt_q != {(AW+1){1'b0}});
  assign push      = ce && in_valid && in_ready;
  assign pop       = ce && out_valid && out_ready;

  // Storage array
  always @(posedge clock)
  begin
    if (push)
      mem[wr_q] <= in_data;
  end

  // Head word shown straight from the array
  always @*
  begin
    out_data = mem[rd_q];
  end

  // Pointers and fill count
  always @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      wr_q  <= {AW{1'b0}};
      rd_q  <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end
    else
    begin
      if (push)
        wr_q <= wr_q + 1'b1;
      if (pop)
        rd_q <= rd_q + 1'b1;
      if (push && !pop)
        cnt_q <= cnt_q + 1'b1;
      else if (pop && !push)
        cnt_q <= cnt_q - 1'b1;
    end
  end
endmodule

/* File: stroke_rom_defs.vh */
// Constants for the stroke character store and decoder
`ifndef STROKE_ROM_DEFS_VH
`define STROKE_ROM_DEFS_VH
`define CODE_W          6
`define WORD_W          32
`define BYTE_W          8
`define STROKE_W        8
`define FIFO_DEPTH      16
`define FIFO_AW         4
// Stroke byte field positions (byte bit 7 is the escape bit)
`define SB_ESC          7
`define SB_INT_HI       7
`define SB_INT_LO       6
`define SB_DIR_HI       5
`define SB_DIR_LO       3
`define SB_LEN_HI       2
`define SB_LEN_LO       0
// Hardware function codes, hex
`define CODE_TAB        7'h09
`define CODE_LF         7'h0A
`define CODE_CR         7'h0D
`define CODE_ALT        7'h7D
// Intensity field value that turns the beam on
`define INT_ON          2'h1
// Reset values
`define BYTE_CNT_RST    2'h0
`define WORD_SEL_RST    1'b0
`endif

/* File: stroke_fifo.v */
// Stroke FIFO is defined beside the decoder in stroke_char_rom_decoder.v

/* File: stroke_rom_chk_sva.sv */
// Port checker for the stroke store and decoder
module stroke_rom_chk (
  input logic       clock,
  input logic       rstn,
  input logic       ce,
  input logic       code_load_pulse,
  input logic       stroke_valid,
  input logic       stroke_ready,
  input logic       stroke_escape_out,
  input logic       stroke_intensity_out,
  input logic [2:0] stroke_direction_out,
  input logic [2:0] stroke_length_out,
  input logic       beam_on,
  input logic       function_code,
  input logic [6:0] function_value,
  input logic       busy
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn || !ce);
  chk_beam_gate: assert property (beam_on == (stroke_valid && stroke_intensity_out))
    else $error("beam output disagrees with valid and intensity");
  chk_head_holds: assert property (stroke_valid && !(stroke_ready && ce) |=> stroke_valid &&
    $stable({stroke_escape_out, stroke_intensity_out, stroke_direction_out, stroke_length_out}))
    else $error("stroke head changed while not taken");
  chk_escape_dark: assert property (stroke_valid && stroke_escape_out |-> !stroke_intensity_out)
    else $error("escape stroke shown with beam on");
  chk_func_inhibit: assert property (function_code |-> function_value[6] == function_value[5])
    else $error("function pulse for a stored character code");
  chk_idle_quiet: assert property (!busy && !stroke_valid |=> !stroke_valid)
    else $error("stroke appeared with no character in progress");
  chk_load_busy: assert property ($rose(code_load_pulse) |-> ##[1:6] busy)
    else $error("load pulse did not start a character");
  chk_no_spurious: assert property ((!code_load_pulse && !busy) [*6] |=> !busy)
    else $error("character started without a load pulse");
  chk_eight_max: assert property ((busy && stroke_ready && ce) [*8] |-> ##2 !busy)
    else $error("character ran past eight strokes");
endmodule

/* File: stroke_sink.sv */
// Stroke consumer model standing in for the vector drawing logic
module stroke_sink (
  input  logic       clock,
  input  logic       rstn,
  input  logic [1:0] mode,
  input  logic       stroke_valid,
  input  logic       stroke_escape_out,
  input  logic       stroke_intensity_out,
  input  logic [2:0] stroke_direction_out,
  input  logic [2:0] stroke_length_out,
  output logic       stroke_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] got [$];
  logic [1:0] phase_q;
  // Ready pacing: 0 prompt, 1 stalled, 2 one cycle in three
  always @(posedge clock or negedge rstn)
    if (!rstn)
    begin
      stroke_ready <= 1'b0;
      phase_q      <= 2'h0;
    end
    else
    begin
      phase_q      <= (phase_q == 2'h2) ? 2'h0 : phase_q + 2'h1;
      stroke_ready <= (mode == 2'h0) || (mode == 2'h2 && phase_q == 2'h0);
      // take fields, length into length register
      if (stroke_valid && stroke_ready)
        got.push_back({stroke_escape_out, stroke_intensity_out, stroke_direction_out,
                       stroke_length_out});
    end
endmodule

/* File: testbench.sv */
// Self-checking bench for the stroke store and decoder
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clock = 0, rstn = 0, pulse = 0, we = 0, ce = 1;
  logic [6:0]  code = 0, waddr = 0;
  logic [31:0] wdata = 0;
  logic [1:0]  mode = 0;
  wire         valid, ready, last_stroke_marker, inten, beam, fcode, busy;
  wire  [2:0]  dir, len;
  wire  [6:0]  fval;
  logic [7:0]  exp_q [$];
  int          fail_count = 0, n_checks = 0, cyc = 0;
  stroke_char_rom_decoder i_dut (.clock(clock), .rstn(rstn), .ce(ce), .code_load_pulse(pulse),
    .char_code(code), .rom_we(we), .rom_waddr(waddr), .rom_wdata(wdata), .stroke_valid(valid),
    .stroke_ready(ready), .stroke_escape_out(last_stroke_marker), .stroke_intensity_out(inten),
    .stroke_direction_out(dir), .stroke_length_out(len), .beam_on(beam), .function_code(fcode),
    .function_value(fval), .busy(busy));
  stroke_sink i_sink (.clock(clock), .rstn(rstn), .mode(mode), .stroke_valid(valid),
    .stroke_escape_out(last_stroke_marker), .stroke_intensity_out(inten), .stroke_direction_out(dir),
    .stroke_length_out(len), .stroke_ready(ready));
  // Clock and hang guard
  always #5 clock = ~clock;
  always @(posedge clock)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      fail_count++;
      stop_test();
    end
  end
  task automatic stop_test();
    if (fail_count == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic check(input logic [7:0] got, input logic [7:0] want);
    n_checks++;
    if (got !== want)
    begin
      fail_count++;
      $display("BAD t=%0t got=%h want=%h", $time, got, want);
    end
  endtask
  // Store a character as two words, first word at word select 0
  task automatic put_char(input logic [5:0] c, input logic [31:0] w0, input logic [31:0] w1);
    @(posedge clock);
    we <= 1'b1; waddr <= {1'b0, c}; wdata <= w0;
    @(posedge clock);
    waddr <= {1'b1, c}; wdata <= w1;
    @(posedge clock);
    we <= 1'b0;
  endtask
  // Code held before and after the pulse rise
  task automatic load(input logic [6:0] c);
    @(posedge clock);
    code <= c;
    repeat (3) @(posedge clock);
    pulse <= 1'b1;
    repeat (4) @(posedge clock);
    pulse <= 1'b0;
  endtask
  // Wait for expected strokes, then compare decoded fields in order
  task automatic drain();
    int k;
    k = 0;
    while (i_sink.got.size() < exp_q.size() && k < 800)
    begin
      @(posedge clock);
      k++;
    end
    repeat (12) @(posedge clock);
    check(8'(i_sink.got.size()), 8'(exp_q.size()));
    foreach (exp_q[i])
      check(i_sink.got[i], {exp_q[i][7], exp_q[i][7:6] == 2'h1, exp_q[i][5:3], exp_q[i][2:0]});
    i_sink.got.delete();
    exp_q.delete();
  endtask
  task automatic t_letter();
    put_char(6'h01, 32'h56447621, 32'h1B44BB56);
    mode <= 2'h0;
    load(7'h41);
    exp_q = '{8'h56, 8'h44, 8'h76, 8'h21, 8'h1B, 8'h44, 8'hBB};
    drain();
  endtask
  task automatic t_full();
    put_char(6'h30, 32'h41126304, 32'h55267738);
    mode <= 2'h2;
    load(7'h30);
    exp_q = '{8'h41, 8'h12, 8'h63, 8'h04, 8'h55, 8'h26, 8'h77, 8'h38};
    drain();
  endtask
  task automatic t_boards();
    logic [6:0] c;
    for (int i = 0; i < 8; i++)
    begin
      c = (i < 4 ? 7'h40 : 7'h00) + 7'(9 * i);
      put_char(c[5:0], {2'h2, 3'(i), 3'(7 - i), 24'h0}, 32'h0);
    end
    for (int i = 0; i < 8; i++)
    begin
      c = (i < 4 ? 7'h40 : 7'h00) + 7'(9 * i);
      load(c);
      exp_q.push_back({2'h2, 3'(i), 3'(7 - i)});
      drain();
    end
  endtask
  task automatic t_stall();
    mode <= 2'h1;
    for (int i = 0; i < 3; i++)
    begin
      load(7'h30);
      repeat (14) @(posedge clock);
      exp_q = {exp_q, 8'h41, 8'h12, 8'h63, 8'h04, 8'h55, 8'h26, 8'h77, 8'h38};
    end
    #1;
    check({7'h0, busy}, 8'h01);
    check({7'h0, valid}, 8'h01);
    check({last_stroke_marker, inten, dir, len}, 8'h41);
    check({7'h0, beam}, 8'h01);
    mode <= 2'h2;
    drain();
  endtask
  task automatic t_functions();
    logic [6:0] f [5] = '{7'h09, 7'h0A, 7'h0D, 7'h7D, 7'h05};
    int seen;
    mode <= 2'h0;
    foreach (f[i])
    begin
      seen = 0;
      load(f[i]);
      // One pulse with the code for functions, none for the illegal code
      repeat (15)
      begin
        @(negedge clock);
        if (fcode === 1'b1 && fval === f[i])
          seen++;
      end
      check(8'(seen), (i < 4) ? 8'h01 : 8'h00);
      check({6'h0, valid, busy}, 8'h00);
    end
  endtask
  // A load pulse while the clock enable is low must leave no trace
  task automatic t_freeze();
    @(posedge clock);
    ce <= 1'b0;
    load(7'h41);
    repeat (6) @(posedge clock);
    ce <= 1'b1;
    repeat (8) @(negedge clock);
    check({6'h0, valid, busy}, 8'h00);
  endtask
  initial
  begin
    repeat (4) @(posedge clock);
    rstn <= 1'b1;
    t_letter();
    t_full();
    t_boards();
    t_stall();
    t_functions();
    t_freeze();
    stop_test();
  end
endmodule
bind stroke_char_rom_decoder stroke_rom_chk i_chk (.clock(clock), .rstn(rstn), .ce(ce),
  .code_load_pulse(code_load_pulse), .stroke_valid(stroke_valid), .stroke_ready(stroke_ready),
  .stroke_escape_out(stroke_escape_out), .stroke_intensity_out(stroke_intensity_out),
  .stroke_direction_out(stroke_direction_out), .stroke_length_out(stroke_length_out),
  .beam_on(beam_on), .function_code(function_code), .function_value(function_value),
  .busy(busy));
